// *** hw/slc_pkg.sv ***
package slc_pkg;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned SAMPLE_W = 9;
  localparam int unsigned NUM_CH   = 4;
  localparam int unsigned CNT_W    = 4;
  localparam int unsigned SYNC_WORD_BITS = 32;

  localparam logic [ADDR_W-1:0] CHAN_EN_ADDR    = 12'h0209;
  localparam logic [ADDR_W-1:0] SYNC_SEL_ADDR   = 12'h020f;
  localparam logic [ADDR_W-1:0] SYNC_FILT_ADDR  = 12'h0210;

  localparam logic [DATA_W-1:0] CHAN_EN_RESET   = 8'h03;
  localparam logic [DATA_W-1:0] SYNC_SEL_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] SYNC_FILT_RESET = 8'h03;

  localparam int unsigned FIRST_PAIR_BIT  = 0;
  localparam int unsigned SECOND_PAIR_BIT = 1;
  localparam int unsigned ONE_CHAN_BIT    = 2;
  localparam int unsigned SEL_LSB  = 0;
  localparam int unsigned SEL_W    = 2;
  localparam int unsigned THR_LSB  = 0;
  localparam int unsigned THR_W    = 5;
  localparam int unsigned RUN_W    = THR_W + 1;

  typedef enum logic [SEL_W-1:0] {
    SLC_SEL_CRC12 = 2'h0,
    SLC_SEL_RSV1  = 2'h1,
    SLC_SEL_FEC   = 2'h2,
    SLC_SEL_RSV3  = 2'h3
  } slc_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } slc_reg_req_t;

  typedef struct packed {
    logic first_pair_on;
    logic second_pair_on;
    logic one_chan_mode;
    logic [NUM_CH-1:0] chan_on;
  } slc_chan_cfg_t;

  typedef struct packed {
    logic send_crc12;
    logic send_fec;
    logic [SYNC_WORD_BITS-1:0] cmd_bits;
  } slc_sync_word_t;

  typedef logic [NUM_CH-1:0][SAMPLE_W-1:0] slc_samples_t;
endpackage

// *** hw/slc_link_cfg.sv ***
`timescale 1ns/100ps
`default_nettype none
module slc_link_cfg #(
  parameter int unsigned SAMPLE_W = slc_pkg::SAMPLE_W,
  parameter int unsigned CNT_W    = slc_pkg::CNT_W
) (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire slc_pkg::slc_reg_req_t         reg_req,
  output var  logic [slc_pkg::DATA_W-1:0]    reg_rdata,
  output var  logic                          reg_rvalid,
  input  wire logic                          link_enable,
  input  wire logic                          link_format_is_6466,
  input  wire logic [CNT_W-1:0]              configured_lane_count,
  input  wire logic [CNT_W-1:0]              configured_converter_count,
  input  wire logic                          sync_n,
  input  wire logic [slc_pkg::NUM_CH-1:0][SAMPLE_W-1:0] chan_samples,
  output var  logic [slc_pkg::NUM_CH-1:0][SAMPLE_W-1:0] frame_slots,
  output var  slc_pkg::slc_chan_cfg_t        chan_cfg,
  output var  logic [CNT_W-1:0]              active_lane_count,
  output var  logic [CNT_W-1:0]              active_converter_count,
  output var  logic                          tail_pad,
  output var  slc_pkg::slc_sync_word_t       sync_word,
  output var  logic                          sync_request,
  output var  logic                          sync_error_report
);
  logic                              first_pair_q;
  logic                              second_pair_q;
  logic                              one_chan_q;
  logic [slc_pkg::SEL_W-1:0]         sel_q;
  logic [slc_pkg::THR_W-1:0]         thr_q;
  logic [slc_pkg::RUN_W-1:0]         run_q;
  logic [slc_pkg::RUN_W-1:0]         need;
  logic                              pair_off;
  logic                              ab_off;
  logic                              cd_off;

  // Register writes; reserved bits are not stored and read back as zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first_pair_q  <= slc_pkg::CHAN_EN_RESET[slc_pkg::FIRST_PAIR_BIT];
      second_pair_q <= slc_pkg::CHAN_EN_RESET[slc_pkg::SECOND_PAIR_BIT];
      one_chan_q    <= slc_pkg::CHAN_EN_RESET[slc_pkg::ONE_CHAN_BIT];
    end else if (reg_req.wr && reg_req.addr == slc_pkg::CHAN_EN_ADDR) begin
      first_pair_q  <= reg_req.wdata[slc_pkg::FIRST_PAIR_BIT];
      second_pair_q <= reg_req.wdata[slc_pkg::SECOND_PAIR_BIT];
      one_chan_q    <= reg_req.wdata[slc_pkg::ONE_CHAN_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_q <= slc_pkg::SYNC_SEL_RESET[slc_pkg::SEL_LSB +: slc_pkg::SEL_W];
    end else if (reg_req.wr && reg_req.addr == slc_pkg::SYNC_SEL_ADDR) begin
      sel_q <= reg_req.wdata[slc_pkg::SEL_LSB +: slc_pkg::SEL_W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      thr_q <= slc_pkg::SYNC_FILT_RESET[slc_pkg::THR_LSB +: slc_pkg::THR_W];
    end else if (reg_req.wr && reg_req.addr == slc_pkg::SYNC_FILT_ADDR) begin
      thr_q <= reg_req.wdata[slc_pkg::THR_LSB +: slc_pkg::THR_W];
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      reg_rdata  <= '0;
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          slc_pkg::CHAN_EN_ADDR: begin
            reg_rdata[slc_pkg::FIRST_PAIR_BIT]  <= first_pair_q;
            reg_rdata[slc_pkg::SECOND_PAIR_BIT] <= second_pair_q;
            reg_rdata[slc_pkg::ONE_CHAN_BIT]    <= one_chan_q;
          end
          slc_pkg::SYNC_SEL_ADDR: begin
            reg_rdata[slc_pkg::SEL_LSB +: slc_pkg::SEL_W] <= sel_q;
          end
          slc_pkg::SYNC_FILT_ADDR: begin
            reg_rdata[slc_pkg::THR_LSB +: slc_pkg::THR_W] <= thr_q;
          end
          default: begin
            reg_rdata <= '0;
          end
        endcase
      end
    end
  end

  // One-channel mode forces B, C and D off regardless of the pair bits
  assign ab_off   = !first_pair_q;
  assign cd_off   = !second_pair_q || one_chan_q;
  assign pair_off = ab_off || cd_off;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chan_cfg <= '0;
    end else begin
      chan_cfg.first_pair_on  <= first_pair_q;
      chan_cfg.second_pair_on <= second_pair_q;
      chan_cfg.one_chan_mode  <= one_chan_q;
      chan_cfg.chan_on[0]     <= first_pair_q;
      chan_cfg.chan_on[1]     <= first_pair_q && !one_chan_q;
      chan_cfg.chan_on[2]     <= second_pair_q && !one_chan_q;
      chan_cfg.chan_on[3]     <= second_pair_q && !one_chan_q;
    end
  end

  // Lane and converter scaling when a pair is off
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      active_lane_count      <= '0;
      active_converter_count <= '0;
      tail_pad               <= 1'b0;
    end else if (pair_off) begin
      active_lane_count      <= CNT_W'((configured_lane_count >> 1)
                                       + CNT_W'(configured_lane_count[0]));
      active_converter_count <= configured_converter_count >> 1;
      tail_pad               <= configured_lane_count[0];
    end else begin
      active_lane_count      <= configured_lane_count;
      active_converter_count <= configured_converter_count;
      tail_pad               <= 1'b0;
    end
  end

  // Frame slot mapping; disabled channels send zeros, except that with the first pair off C and D always fill slots 0 and 1
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      frame_slots <= '0;
    end else if (ab_off) begin
      frame_slots[0] <= chan_samples[2];
      frame_slots[1] <= chan_samples[3];
      frame_slots[2] <= '0;
      frame_slots[3] <= '0;
    end else begin
      frame_slots[0] <= chan_samples[0];
      frame_slots[1] <= one_chan_q ? '0 : chan_samples[1];
      frame_slots[2] <= cd_off ? '0 : chan_samples[2];
      frame_slots[3] <= cd_off ? '0 : chan_samples[3];
    end
  end

  // Sync word content; outside 64b/66b formats both selects stay low
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_word <= '0;
    end else begin
      sync_word.send_crc12 <= link_format_is_6466
                              && sel_q == slc_pkg::SLC_SEL_CRC12;
      sync_word.send_fec   <= link_format_is_6466
                              && sel_q == slc_pkg::SLC_SEL_FEC;
      sync_word.cmd_bits   <= '0;
    end
  end

  // Low-run filter: the count saturates at threshold plus one
  assign need = slc_pkg::RUN_W'(thr_q) + slc_pkg::RUN_W'(1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !link_enable) begin
      run_q <= '0;
    end else if (sync_n) begin
      run_q <= '0;
    end else if (run_q < need) begin
      run_q <= run_q + slc_pkg::RUN_W'(1);
    end
  end

  // Request is a level held while the qualified low run lasts
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !link_enable) begin
      sync_request      <= 1'b0;
      sync_error_report <= 1'b0;
    end else begin
      sync_request      <= !sync_n && (run_q + slc_pkg::RUN_W'(1) >= need);
      // A short run is only flagged; nothing else reacts to it
      sync_error_report <= sync_n && run_q != '0 && run_q < need;
    end
  end
endmodule
`default_nettype wire

// *** sim/slc_rx_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module slc_rx_model (
  input  wire logic       ref_clk,
  input  wire logic       start,
  input  wire logic [5:0] low_len,
  output var  logic       sync_n
);
  logic [5:0] left_q = 6'h00;
  always_ff @(posedge ref_clk) begin
    if (start) begin
      left_q <= low_len;
    end else if (left_q != 6'h00) begin
      left_q <= left_q - 6'h01;
    end
  end
  // Idles high between requests, as the pulled-up line would
  assign sync_n = (left_q == 6'h00);
endmodule
`default_nettype wire

// *** sim/slc_link_cfg_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module slc_link_cfg_checker (
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire slc_pkg::slc_reg_req_t      reg_req,
  input wire logic [slc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       reg_rvalid,
  input wire logic                       link_enable,
  input wire logic                       link_format_is_6466,
  input wire logic                       sync_n,
  input wire slc_pkg::slc_chan_cfg_t     chan_cfg,
  input wire slc_pkg::slc_sync_word_t    sync_word,
  input wire logic                       sync_request,
  input wire logic                       sync_error_report
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [4:0] thr_q;
  logic [5:0] run_q;
  logic       err_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      thr_q <= 5'h3;
    end else if (reg_req.wr && reg_req.addr == slc_pkg::SYNC_FILT_ADDR) begin
      thr_q <= reg_req.wdata[4:0];
    end
  end
  // Saturates so a long low run cannot wrap back under the threshold
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !link_enable || sync_n) begin
      run_q <= 6'h00;
    end else if (run_q != 6'h3f) begin
      run_q <= run_q + 6'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    err_q <= !sys_rst && link_enable && sync_n && run_q != 6'h00 && run_q <= {1'b0, thr_q};
  end
  cmd_zero_a: assert property (sync_word.cmd_bits == '0)
    else $error("sync word command bits not zero");
  one_chan_a: assert property (chan_cfg.one_chan_mode |-> chan_cfg.chan_on[3:1] == 3'h0)
    else $error("single channel mode left B C D on");
  pair_map_a: assert property (!$past(sys_rst, 2) |-> chan_cfg.chan_on == {{2{chan_cfg.second_pair_on && !chan_cfg.one_chan_mode}}, chan_cfg.first_pair_on && !chan_cfg.one_chan_mode, chan_cfg.first_pair_on})
    else $error("channel enables do not follow pair bits");
  sel_fec_a: assert property (reg_req.wr && reg_req.addr == slc_pkg::SYNC_SEL_ADDR && reg_req.wdata[1:0] == 2'h2 ##1 link_format_is_6466 |=> sync_word.send_fec && !sync_word.send_crc12)
    else $error("sync word select 2 did not send fec");
  fmt_off_a: assert property (!link_format_is_6466 |=> !sync_word.send_crc12 && !sync_word.send_fec)
    else $error("sync word content active outside 64b66b");
  req_exact_a: assert property (sync_request == (run_q > {1'b0, thr_q}))
    else $error("sync request does not match low run length");
  err_pulse_a: assert property (sync_error_report == err_q)
    else $error("error report does not match short low run");
  thr_read_a: assert property (reg_req.rd && reg_req.addr == slc_pkg::SYNC_FILT_ADDR |=> reg_rvalid && reg_rdata == {3'h0, thr_q})
    else $error("threshold readback wrong");
endmodule
bind slc_link_cfg slc_link_cfg_checker slc_link_cfg_checker_inst (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .link_enable(link_enable), .link_format_is_6466(link_format_is_6466), .sync_n(sync_n),
  .chan_cfg(chan_cfg), .sync_word(sync_word), .sync_request(sync_request),
  .sync_error_report(sync_error_report));
`default_nettype wire

// *** sim/slc_link_cfg_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module slc_link_cfg_bench;
  logic ref_clk = 1'b0, sys_rst = 1'b1, link_enable = 1'b0, link_format_is_6466 = 1'b0;
  logic start = 1'b0, reg_rvalid, tail_pad, sync_n, sync_request, sync_error_report;
  logic [5:0] low_len = 6'h00;
  logic [3:0] configured_lane_count = 4'h5, configured_converter_count = 4'h4;
  logic [3:0] active_lane_count, active_converter_count;
  logic [7:0] reg_rdata;
  slc_pkg::slc_reg_req_t  reg_req = '0;
  slc_pkg::slc_samples_t  chan_samples = {9'h104, 9'h103, 9'h102, 9'h101};
  slc_pkg::slc_samples_t  frame_slots;
  slc_pkg::slc_chan_cfg_t chan_cfg;
  slc_pkg::slc_sync_word_t sync_word;
  int err_total, num_checks, err_seen, req_cyc, cycles, e0, r0, thr;
  int lens [6] = '{3, 4, 6, 2, 2, 1};
  logic [7:0] cfgs [4] = '{8'h03, 8'h01, 8'h02, 8'h07};
  logic [3:0] ons [4] = '{4'hf, 4'h3, 4'hc, 4'h1};
  slc_link_cfg slc_link_cfg_inst (.ref_clk, .sys_rst, .reg_req, .reg_rdata, .reg_rvalid,
    .link_enable, .link_format_is_6466, .configured_lane_count, .configured_converter_count,
    .sync_n, .chan_samples, .frame_slots, .chan_cfg, .active_lane_count,
    .active_converter_count, .tail_pad, .sync_word, .sync_request, .sync_error_report);
  slc_rx_model slc_rx_model_inst (.ref_clk, .start, .low_len, .sync_n);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
    #1 chk({reg_rvalid, reg_rdata}, {1'b1, e});
    @(posedge ref_clk);
  endtask
  task automatic run_low(input int n);
    start <= 1'b1;
    low_len <= 6'(n);
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (n + 3) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (sync_error_report === 1'b1)
      err_seen++;
    if (sync_request === 1'b1)
      req_cyc++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(12'h0209, 8'h03);
    rd(12'h020f, 8'h00);
    rd(12'h0210, 8'h03);
    wr(12'h020f, 8'hfe);
    rd(12'h020f, 8'h02);
    wr(12'h0211, 8'h5a);
    rd(12'h0211, 8'h00);
    link_format_is_6466 <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(12'h020f, 8'(s));
      @(posedge ref_clk);
      chk({sync_word.send_crc12, sync_word.send_fec}, {s == 0, s == 2});
    end
    link_format_is_6466 <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({sync_word.send_crc12, sync_word.send_fec}, 2'h0);
    for (int i = 0; i < 4; i++) begin
      wr(12'h0209, cfgs[i]);
      repeat (2) @(posedge ref_clk);
      chk(chan_cfg.chan_on, ons[i]);
      chk({active_lane_count, active_converter_count, tail_pad}, i == 0 ? 9'h0a8 : 9'h065);
      chk(frame_slots[0], i == 2 ? chan_samples[2] : chan_samples[0]);
      chk(frame_slots[1], i == 3 ? 9'h000 : (i == 2 ? chan_samples[3] : chan_samples[1]));
      chk(frame_slots[2], i == 0 ? chan_samples[2] : 9'h000);
    end
    wr(12'h0209, 8'h03);
    link_enable <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      thr = (i == 5) ? 0 : 3;
      if (i == 5) begin
        link_enable <= 1'b0;
        wr(12'h0210, 8'h00);
        link_enable <= 1'b1;
        @(posedge ref_clk);
      end
      e0 = err_seen;
      r0 = req_cyc;
      run_low(lens[i]);
      chk(64'(err_seen - e0), 64'(lens[i] <= thr));
      chk(64'(req_cyc - r0), 64'(lens[i] > thr ? lens[i] - thr : 0));
    end
    end_of_test();
  end
endmodule
`default_nettype wire
